// >>> include/dmic_consts.svh
// Constants for the debug mini instruction cache: geometry, offsets, fields.
`ifndef DMIC_CONSTS_SVH
`define DMIC_CONSTS_SVH

// Geometry: 32 sets, 2 ways, 8 words of 32 bits per line.
`define DMIC_SETS       32
`define DMIC_WAYS       2
`define DMIC_LINES      64
`define DMIC_WORDS      8
`define DMIC_TAG_BITS   22
`define DMIC_SET_LO     5
`define DMIC_SET_HI     9
`define DMIC_TAG_LO     10
`define DMIC_WORD_LO    2
`define DMIC_WORD_HI    4
`define DMIC_PID_LO     25

// Register offsets on the handler's register port.
`define DMIC_OFF_CTRL   4'h0
`define DMIC_OFF_RX     4'h4
`define DMIC_OFF_TX     4'h8
`define DMIC_OFF_STAT   4'hC

// Debug control register fields and reset value.
`define DMIC_CTRL_GE    31
`define DMIC_CTRL_HALT  30
`define DMIC_CTRL_TRAP  16
`define DMIC_CTRL_RELOC 13
`define DMIC_CTRL_RESET 32'h00000000

// Status register fields.
`define DMIC_ST_TR      0
`define DMIC_ST_RR      1
`define DMIC_ST_REFUSED 2
`define DMIC_ST_LDMODE  3

// Vector table bases and the set that holds both override tables.
`define DMIC_VEC_LOW    32'h00000000
`define DMIC_VEC_HIGH   32'hFFFF0000
`define DMIC_VEC_SET    5'h00

`endif

// >>> include/dmic_pkg.sv
// Types shared by the debug mini instruction cache modules.
package dmic_pkg;
  `include "dmic_consts.svh"

  // Operations of the scan-path cache load function.
  typedef enum logic [1:0] {
    DMIC_OP_LINE,
    DMIC_OP_INV_LINE,
    DMIC_OP_INV_ALL
  } dmic_op_t;

  // Complete state of the cache top module.
  typedef struct packed {
    logic [`DMIC_LINES-1:0]                         valid;
    logic [`DMIC_LINES-1:0][`DMIC_TAG_BITS-1:0]     tag;
    logic [`DMIC_LINES-1:0][`DMIC_WORDS-1:0][31:0]  data;
    logic [`DMIC_SETS-1:0]                          rr_ptr;
    logic [31:0]                                    ctrl;
    logic [31:0]                                    rx_data;
    logic [31:0]                                    tx_data;
    logic                                           rr_flag;
    logic                                           tr_flag;
    logic                                           refused;
    logic                                           rst_d;
    logic                                           fetch_done;
    logic                                           fetch_hit;
    logic [31:0]                                    fetch_word;
    logic [31:0]                                    rdata;
    logic                                           exc;
    logic [31:0]                                    exc_vector;
    logic                                           exc_vec_hit;
  } dmic_state_t;
endpackage : dmic_pkg

// >>> hdl/dmic_xlate.sv
// Lookup address former: process identifier remap unless in debug state.
`timescale 1ns/1ps
`include "dmic_consts.svh"
module dmic_xlate (
  input  wire logic [31:0] va,
  input  wire logic [6:0]  process_identifier_remap,
  input  wire logic        special_debug,
  output logic      [31:0] mva
);
  // Low 32 MB addresses are remapped into the process slot; the debug
  // state bypasses this so handler fetches see the raw address.
  always_comb begin
    mva = va;
    if (!special_debug && (va[31:`DMIC_PID_LO] == '0)) begin
      mva = {process_identifier_remap, va[`DMIC_PID_LO-1:0]};
    end
  end
endmodule : dmic_xlate

// >>> hdl/dmic_top.sv
// Debug mini instruction cache with scan load, invalidation and handshakes.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "dmic_consts.svh"
module dmic_top (
  input  wire logic                 CLK_SYS,
  input  wire logic                 NRST,
  input  wire logic                 FETCH_REQ,
  input  wire logic [31:0]          FETCH_VA,
  input  wire logic                 SPECIAL_DEBUG,
  input  wire logic [6:0]           PROCESS_IDENTIFIER_REMAP,
  input  wire logic                 INV_LINE_REQ,
  input  wire logic [31:0]          INV_LINE_VA,
  input  wire logic                 INV_ALL_REQ,
  input  wire logic                 CORE_RST,
  input  wire logic                 DBG_EVENT,
  input  wire logic                 LOAD_MODE,
  input  wire logic                 LOAD_REQ,
  input  wire dmic_pkg::dmic_op_t   LOAD_OP,
  input  wire logic [31:0]          LOAD_VA,
  input  wire logic [255:0]         LOAD_DATA,
  input  wire logic                 DBG_RX_WR,
  input  wire logic [31:0]          DBG_RX_DATA,
  input  wire logic                 DBG_TX_RD,
  input  wire logic [3:0]           REG_ADDR,
  input  wire logic [31:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [31:0]          REG_RDATA,
  output logic                      FETCH_DONE,
  output logic                      FETCH_HIT,
  output logic      [31:0]          FETCH_WORD,
  output logic                      RX_READY,
  output logic                      TX_READY,
  output logic      [31:0]          DBG_TX_DATA,
  output logic                      DEBUG_EXC,
  output logic      [31:0]          EXC_VECTOR,
  output logic                      EXC_VEC_HIT
);
  import dmic_pkg::*;

  dmic_state_t st;
  dmic_state_t next_st;
  logic [31:0] fetch_mva;
  logic [31:0] inv_mva;

  // Returns {hit, way} for an address against the valid lines of its set.
  function automatic logic [1:0] hit_way(input dmic_state_t s,
                                         input logic [31:0] a);
    logic [1:0] r;
    logic [5:0] i;
    r = 2'h0;
    for (int w = 0; w < `DMIC_WAYS; w++) begin
      i = {a[`DMIC_SET_HI:`DMIC_SET_LO], w[0]};
      if (s.valid[i] && (s.tag[i] == a[31:`DMIC_TAG_LO])) begin
        r = {1'b1, w[0]};
      end
    end
    return r;
  endfunction : hit_way

  // Fetch lookups are remapped for applications and raw in debug state.
  dmic_xlate u_fetch_xlate (
    .va            (FETCH_VA),
    .process_identifier_remap           (PROCESS_IDENTIFIER_REMAP),
    .special_debug (SPECIAL_DEBUG),
    .mva           (fetch_mva)
  );

  // Coprocessor line invalidates come from application context too.
  dmic_xlate u_inv_xlate (
    .va            (INV_LINE_VA),
    .process_identifier_remap           (PROCESS_IDENTIFIER_REMAP),
    .special_debug (SPECIAL_DEBUG),
    .mva           (inv_mva)
  );

  // Next-state logic. Later blocks override earlier ones, so a scan-path
  // operation wins over a coprocessor invalidate in the same cycle, and
  // every flag set comes after its clear so a simultaneous event survives.
  always_comb begin
    logic [1:0] hw;
    logic [4:0] set;
    logic [5:0] idx;
    logic       ok;
    logic       way;
    logic [31:0] vec;
    logic [31:0] line_va;
    hw  = 2'h0;
    set = 5'h00;
    idx = 6'h00;
    ok  = 1'b0;
    way = 1'b0;
    vec = `DMIC_VEC_LOW;
    line_va = 32'h00000000;
    next_st = st;

    // Fetch lookup: a miss is only reported, never filled from memory.
    hw = hit_way(st, fetch_mva);
    next_st.fetch_done = FETCH_REQ;
    next_st.fetch_hit  = FETCH_REQ && hw[1];
    next_st.fetch_word = 32'h00000000;
    if (FETCH_REQ && hw[1]) begin
      idx = {fetch_mva[`DMIC_SET_HI:`DMIC_SET_LO], hw[0]};
      next_st.fetch_word =
        st.data[idx][fetch_mva[`DMIC_WORD_HI:`DMIC_WORD_LO]];
    end

    // Clears first: debugger drain of transmit, handler read of receive.
    if (DBG_TX_RD) begin
      next_st.tr_flag = 1'b0;
    end
    next_st.rdata = 32'h00000000;
    if (REG_RD) begin
      case (REG_ADDR)
        `DMIC_OFF_CTRL: begin
          next_st.rdata = st.ctrl;
        end
        `DMIC_OFF_RX: begin
          next_st.rdata   = st.rx_data;
          next_st.rr_flag = 1'b0;
        end
        `DMIC_OFF_TX: begin
          next_st.rdata = st.tx_data;
        end
        `DMIC_OFF_STAT: begin
          next_st.rdata[`DMIC_ST_TR]      = st.tr_flag;
          next_st.rdata[`DMIC_ST_RR]      = st.rr_flag;
          next_st.rdata[`DMIC_ST_REFUSED] = st.refused;
          next_st.rdata[`DMIC_ST_LDMODE]  = LOAD_MODE;
          next_st.refused                 = 1'b0;
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end

    // Register writes; a transmit write raises the scan ready bit.
    if (REG_WR) begin
      case (REG_ADDR)
        `DMIC_OFF_CTRL: begin
          next_st.ctrl = REG_WDATA;
        end
        `DMIC_OFF_TX: begin
          next_st.tx_data = REG_WDATA;
          next_st.tr_flag = 1'b1;
        end
        default: begin
          next_st.ctrl = next_st.ctrl;
        end
      endcase
    end

    // Debugger receive write over the scan path.
    if (DBG_RX_WR) begin
      next_st.rx_data = DBG_RX_DATA;
      next_st.rr_flag = 1'b1;
    end

    // Coprocessor line invalidate clears only a line that hits.
    if (INV_LINE_REQ) begin
      hw = hit_way(st, inv_mva);
      if (hw[1]) begin
        idx = {inv_mva[`DMIC_SET_HI:`DMIC_SET_LO], hw[0]};
        next_st.valid[idx] = 1'b0;
      end
    end
    // A coprocessor whole-cache invalidate is for the main cache only;
    // INV_ALL_REQ is deliberately ignored here.

    // Processor reset keeps a halted or loading cache intact.
    if (CORE_RST && !st.ctrl[`DMIC_CTRL_HALT] && !LOAD_MODE) begin
      next_st.valid = '0;
    end

    // Scan-path cache load function: the only way lines become valid.
    if (LOAD_REQ) begin
      set = LOAD_VA[`DMIC_SET_HI:`DMIC_SET_LO];
      case (LOAD_OP)
        DMIC_OP_INV_ALL: begin
          next_st.valid = '0;
        end
        DMIC_OP_INV_LINE: begin
          hw = hit_way(st, LOAD_VA);
          if (hw[1]) begin
            next_st.valid[{set, hw[0]}] = 1'b0;
          end
        end
        DMIC_OP_LINE: begin
          // Set 0 is reserved for the two override vector tables, each
          // pinned to its own way so neither can evict the other.
          ok  = 1'b1;
          way = st.rr_ptr[set];
          if (set == `DMIC_VEC_SET) begin
            // Compare whole line addresses; the word bits play no part.
            line_va = LOAD_VA >> `DMIC_SET_LO;
            if (line_va == (`DMIC_VEC_LOW >> `DMIC_SET_LO)) begin
              way = 1'b0;
            end else if (line_va == (`DMIC_VEC_HIGH >> `DMIC_SET_LO)) begin
              way = 1'b1;
            end else begin
              ok = 1'b0;
              next_st.refused = 1'b1;
            end
          end else begin
            next_st.rr_ptr[set] = ~st.rr_ptr[set];
          end
          if (ok) begin
            idx = {set, way};
            next_st.tag[idx]   = LOAD_VA[31:`DMIC_TAG_LO];
            next_st.data[idx]  = LOAD_DATA;
            next_st.valid[idx] = 1'b1;
          end
        end
        default: begin
          next_st.refused = 1'b1;
        end
      endcase
    end

    // Debug exceptions. The reset trap fires on release of reset whatever
    // the global enable says; in that cycle no other event is taken.
    next_st.rst_d = CORE_RST;
    next_st.exc   = 1'b0;
    vec = st.ctrl[`DMIC_CTRL_RELOC] ? `DMIC_VEC_HIGH : `DMIC_VEC_LOW;
    if (st.rst_d && !CORE_RST && st.ctrl[`DMIC_CTRL_TRAP]) begin
      next_st.exc = 1'b1;
    end else if (!CORE_RST && !st.rst_d && DBG_EVENT &&
                 st.ctrl[`DMIC_CTRL_GE] && !SPECIAL_DEBUG) begin
      next_st.exc = 1'b1;
    end
    if (next_st.exc) begin
      hw = hit_way(st, vec);
      next_st.exc_vector  = vec;
      next_st.exc_vec_hit = hw[1];
    end
  end

  // State register. Power-on reset empties the cache; only the core's
  // own reset input follows the halt-mode exception.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st             <= '0;
      st.ctrl        <= `DMIC_CTRL_RESET;
      st.exc_vector  <= `DMIC_VEC_LOW;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign REG_RDATA   = st.rdata;
  assign FETCH_DONE  = st.fetch_done;
  assign FETCH_HIT   = st.fetch_hit;
  assign FETCH_WORD  = st.fetch_word;
  assign RX_READY    = st.rr_flag;
  assign TX_READY    = st.tr_flag;
  assign DBG_TX_DATA = st.tx_data;
  assign DEBUG_EXC   = st.exc;
  assign EXC_VECTOR  = st.exc_vector;
  assign EXC_VEC_HIT = st.exc_vec_hit;

  // Checks on the cache and handshake behaviour.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  property p_no_alloc;
    !LOAD_REQ |=> ((st.valid & ~$past(st.valid)) == '0);
  endproperty
  a_no_alloc: assert property (p_no_alloc)
    else $error("line became valid without a scan load");

  property p_inv_all_keep;
    INV_ALL_REQ && !INV_LINE_REQ && !LOAD_REQ && !CORE_RST
      |=> st.valid == $past(st.valid);
  endproperty
  a_inv_all_keep: assert property (p_inv_all_keep)
    else $error("global coprocessor invalidate changed the cache");

  property p_scan_inv_all;
    LOAD_REQ && (LOAD_OP == DMIC_OP_INV_ALL) |=> st.valid == '0;
  endproperty
  a_scan_inv_all: assert property (p_scan_inv_all)
    else $error("scan invalidate-all left a valid line");

  property p_rst_inv;
    CORE_RST && !st.ctrl[`DMIC_CTRL_HALT] && !LOAD_MODE && !LOAD_REQ
      |=> st.valid == '0;
  endproperty
  a_rst_inv: assert property (p_rst_inv)
    else $error("processor reset did not invalidate the cache");

  property p_rst_keep;
    CORE_RST && st.ctrl[`DMIC_CTRL_HALT] && !LOAD_REQ && !INV_LINE_REQ
      |=> st.valid == $past(st.valid);
  endproperty
  a_rst_keep: assert property (p_rst_keep)
    else $error("reset in halt mode disturbed the cache");

  property p_rx_ready;
    DBG_RX_WR |=> RX_READY && (st.rx_data == $past(DBG_RX_DATA));
  endproperty
  a_rx_ready: assert property (p_rx_ready)
    else $error("receive write did not raise receive ready");

  property p_tx_ready;
    REG_WR && (REG_ADDR == `DMIC_OFF_TX) |=> TX_READY;
  endproperty
  a_tx_ready: assert property (p_tx_ready)
    else $error("transmit write did not raise transmit ready");

  property p_trap;
    st.rst_d && !CORE_RST && st.ctrl[`DMIC_CTRL_TRAP] |=> DEBUG_EXC;
  endproperty
  a_trap: assert property (p_trap)
    else $error("reset trap did not raise a debug exception");

  property p_exc_gate;
    DEBUG_EXC |-> $past(st.ctrl[`DMIC_CTRL_GE]) || $past(st.rst_d);
  endproperty
  a_exc_gate: assert property (p_exc_gate)
    else $error("debug exception while globally disabled");

  property p_vector;
    DEBUG_EXC |-> EXC_VECTOR == ($past(st.ctrl[`DMIC_CTRL_RELOC]) ?
                                 `DMIC_VEC_HIGH : `DMIC_VEC_LOW);
  endproperty
  a_vector: assert property (p_vector)
    else $error("debug vector does not follow relocation");

  property p_fetch;
    FETCH_REQ |=> FETCH_DONE ##1 (!FETCH_DONE || $past(FETCH_REQ));
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch answer not given one cycle after request");

  cover property (FETCH_DONE && FETCH_HIT);
  cover property (LOAD_REQ && (LOAD_OP == DMIC_OP_LINE) ##1 st.refused);
  cover property (DEBUG_EXC && EXC_VEC_HIT);
  cover property (DBG_RX_WR && REG_RD && (REG_ADDR == `DMIC_OFF_RX));
endmodule : dmic_top

// >>> testbench/dmic_host_model.sv
// Debugger host model: scan-path loads and the receive/transmit handshake.
`timescale 1ns/1ps
module dmic_host_model (
  input  wire logic          clk,
  input  wire logic          tx_ready,
  output logic               load_mode,
  output logic               load_req,
  output dmic_pkg::dmic_op_t load_op,
  output logic      [31:0]   load_va,
  output logic      [255:0]  load_data,
  output logic               rx_wr,
  output logic      [31:0]   rx_data,
  output logic               tx_rd
);
  import dmic_pkg::*;

  // Idle values from time zero.
  initial begin
    {load_mode, load_req, rx_wr, tx_rd} = 4'h0;
    load_op = DMIC_OP_LINE;
    {load_va, load_data, rx_data} = '0;
  end

  // Enter or leave the load mode.
  task automatic set_mode(input logic m);
    @(posedge clk);
    load_mode <= m;
  endtask : set_mode

  // One operation with the whole line in one request.
  task automatic scan_op(input dmic_op_t op, input logic [31:0] va,
                         input logic [255:0] d);
    @(posedge clk);
    load_req  <= 1'b1;
    load_op   <= op;
    load_va   <= va;
    load_data <= d;
    @(posedge clk);
    load_req  <= 1'b0;
    load_va   <= ~va; // Released lines must not keep the last value.
    load_data <= ~d;
  endtask : scan_op

  // Receive write; the settle wait after a download is always kept.
  task automatic rx_write(input logic [31:0] d);
    repeat (15) @(posedge clk);
    rx_wr   <= 1'b1;
    rx_data <= d;
    @(posedge clk);
    rx_wr   <= 1'b0;
    rx_data <= ~d;
  endtask : rx_write

  // Drain the transmit word once the handler has posted it.
  task automatic tx_drain();
    for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(posedge clk);
    tx_rd <= 1'b1;
    @(posedge clk);
    tx_rd <= 1'b0;
  endtask : tx_drain
endmodule : dmic_host_model

// >>> testbench/test_debug_mini_icache.sv
// Self-checking bench for the debug mini instruction cache.
`timescale 1ns/1ps
`include "dmic_consts.svh"
module test_debug_mini_icache;
  import dmic_pkg::*;
  logic clk_sys, nrst, fetch_req, special_debug, inv_line_req, inv_all_req;
  logic core_rst, dbg_event, reg_wr, reg_rd, rd_pend;
  logic load_mode, load_req, rx_wr, tx_rd, fetch_done, fetch_hit;
  logic rx_ready, tx_ready, debug_exc, exc_vec_hit;
  logic [6:0] process_identifier_remap;
  logic [3:0] reg_addr;
  logic [31:0] fetch_va, inv_line_va, reg_wdata, reg_rdata, fetch_word;
  logic [31:0] load_va, rx_data, dbg_tx_data, exc_vector;
  logic [31:0] seed = 32'h00000062;
  logic [31:0] va_a, va_p, rnd_word, vr [3];
  logic [255:0] load_data, da, dp, dr [3], dv [2];
  dmic_op_t load_op;
  logic [32:0] fq [$], rq [$], eq [$];
  int err_count = 0;
  int num_checks = 0;

  // Clock at 40 MHz.
  always #12.5 clk_sys = ~clk_sys;

  dmic_host_model host (.clk(clk_sys), .tx_ready(tx_ready),
    .load_mode(load_mode), .load_req(load_req), .load_op(load_op),
    .load_va(load_va), .load_data(load_data), .rx_wr(rx_wr),
    .rx_data(rx_data), .tx_rd(tx_rd));

  dmic_top dut_u (.CLK_SYS(clk_sys), .NRST(nrst), .FETCH_REQ(fetch_req),
    .FETCH_VA(fetch_va), .SPECIAL_DEBUG(special_debug), .PROCESS_IDENTIFIER_REMAP(process_identifier_remap),
    .INV_LINE_REQ(inv_line_req), .INV_LINE_VA(inv_line_va),
    .INV_ALL_REQ(inv_all_req), .CORE_RST(core_rst), .DBG_EVENT(dbg_event),
    .LOAD_MODE(load_mode), .LOAD_REQ(load_req), .LOAD_OP(load_op),
    .LOAD_VA(load_va), .LOAD_DATA(load_data), .DBG_RX_WR(rx_wr),
    .DBG_RX_DATA(rx_data), .DBG_TX_RD(tx_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FETCH_DONE(fetch_done), .FETCH_HIT(fetch_hit),
    .FETCH_WORD(fetch_word), .RX_READY(rx_ready), .TX_READY(tx_ready),
    .DBG_TX_DATA(dbg_tx_data), .DEBUG_EXC(debug_exc),
    .EXC_VECTOR(exc_vector), .EXC_VEC_HIT(exc_vec_hit));

  // Xorshift source; one random line is eight draws.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [255:0] mk_line();
    logic [255:0] l;
    for (int i = 0; i < 8; i++) l[32*i +: 32] = rnd();
    return l;
  endfunction : mk_line

  // Compare and count.
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp,
                     input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Handler register port tasks; reads note the expected word.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rq.push_back({1'b0, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // Fetch lookup; the expected word is picked by address bits 4:2.
  task automatic fetch(input logic [31:0] va, input logic h,
                       input logic [255:0] l);
    @(posedge clk_sys);
    fetch_req <= 1'b1;
    fetch_va  <= va;
    fq.push_back({h, h ? l[32*va[4:2] +: 32] : 32'h0});
    @(posedge clk_sys);
    fetch_req <= 1'b0;
  endtask : fetch

  // Watcher: takes the oldest note whenever a result shows up.
  always @(negedge clk_sys) begin
    if (rd_pend) chk(reg_rdata, rq.pop_front(), "read");
    rd_pend = reg_rd;
    if (fetch_done === 1'b1) chk({fetch_hit, fetch_word}, fq.pop_front(),
                                 "fetch");
    if (debug_exc === 1'b1 && eq.size() == 0) chk(1, 0, "stray exception");
    else if (debug_exc === 1'b1) chk({exc_vec_hit, exc_vector},
                                     eq.pop_front(), "exception");
  end

  // Watchdog well beyond the sequence length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    rd_pend = 1'b0;
    {fetch_req, inv_line_req, inv_all_req, core_rst, dbg_event} = 5'h00;
    {reg_wr, reg_rd, special_debug, process_identifier_remap, reg_addr} = 14'h0800;
    {fetch_va, inv_line_va, reg_wdata} = '0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`DMIC_OFF_CTRL, `DMIC_CTRL_RESET);
    rd(`DMIC_OFF_STAT, 32'h0);
    rnd_word = rnd();
    va_a = {7'h00, rnd_word[24:10], 5'h03, 5'h00};
    da = mk_line();
    host.scan_op(DMIC_OP_LINE, va_a, da);
    for (int w = 0; w < 8; w++) fetch(va_a | (w << 2), 1'b1, da);
    special_debug <= 1'b0;
    fetch(32'h00000C80, 1'b0, da);
    fetch(32'h00000C80, 1'b0, da);
    for (int i = 0; i < 3; i++) begin
      rnd_word = rnd();
      vr[i] = {rnd_word[31:12], i[1:0], 5'h05, 5'h00};
      dr[i] = mk_line();
      host.scan_op(DMIC_OP_LINE, vr[i], dr[i]);
    end
    fetch(vr[0], 1'b0, dr[0]);
    fetch(vr[1], 1'b1, dr[1]);
    fetch(vr[2], 1'b1, dr[2]);
    rnd_word = rnd();
    va_p = {7'h2A, rnd_word[24:10], 5'h06, 5'h04};
    dp = mk_line();
    host.scan_op(DMIC_OP_LINE, va_p, dp);
    process_identifier_remap <= 7'h2A;
    fetch({7'h00, va_p[24:0]}, 1'b1, dp);
    special_debug <= 1'b1;
    fetch({7'h00, va_p[24:0]}, 1'b0, dp);
    fetch(va_p, 1'b1, dp);
    special_debug <= 1'b0;
    process_identifier_remap <= 7'h00;
    @(posedge clk_sys);
    inv_all_req <= 1'b1;
    @(posedge clk_sys);
    inv_all_req <= 1'b0;
    fetch(va_a, 1'b1, da);
    inv_line_req <= 1'b1;
    inv_line_va  <= va_a;
    @(posedge clk_sys);
    inv_line_req <= 1'b0;
    fetch(va_a, 1'b0, da);
    host.scan_op(DMIC_OP_INV_LINE, vr[1], '0);
    fetch(vr[1], 1'b0, dr[1]);
    fetch(vr[2], 1'b1, dr[2]);
    host.scan_op(DMIC_OP_INV_ALL, '0, '0);
    fetch(vr[2], 1'b0, dr[2]);
    host.scan_op(DMIC_OP_LINE, 32'h00000400, da);
    rd(`DMIC_OFF_STAT, 32'h4);
    rd(`DMIC_OFF_STAT, 32'h0);
    fetch(32'h00000400, 1'b0, da);
    dv[0] = mk_line();
    dv[1] = mk_line();
    host.scan_op(DMIC_OP_LINE, `DMIC_VEC_LOW, dv[0]);
    host.scan_op(DMIC_OP_LINE, `DMIC_VEC_HIGH, dv[1]);
    fetch(`DMIC_VEC_LOW, 1'b1, dv[0]);
    fetch(`DMIC_VEC_HIGH | 32'h1C, 1'b1, dv[1]);
    host.set_mode(1'b1);
    rd(`DMIC_OFF_STAT, 32'h8);
    core_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    core_rst <= 1'b0;
    host.set_mode(1'b0);
    fetch(`DMIC_VEC_LOW, 1'b1, dv[0]);
    wr(`DMIC_OFF_CTRL, 32'h40000000);
    core_rst <= 1'b1;
    wr(`DMIC_OFF_CTRL, 32'h40010000);
    eq.push_back({1'b1, `DMIC_VEC_LOW});
    core_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    fetch(`DMIC_VEC_HIGH, 1'b1, dv[1]);
    dbg_event <= 1'b1;
    @(posedge clk_sys);
    dbg_event <= 1'b0;
    wr(`DMIC_OFF_CTRL, 32'hC0002000);
    eq.push_back({1'b1, `DMIC_VEC_HIGH});
    dbg_event <= 1'b1;
    @(posedge clk_sys);
    dbg_event <= 1'b0;
    wr(`DMIC_OFF_CTRL, 32'h0);
    core_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    core_rst <= 1'b0;
    fetch(`DMIC_VEC_LOW, 1'b0, dv[0]);
    host.rx_write(32'hA5C3_0F1E);
    @(negedge clk_sys);
    chk(rx_ready, 1, "receive ready");
    rd(`DMIC_OFF_RX, 32'hA5C3_0F1E);
    @(negedge clk_sys);
    chk(rx_ready, 0, "receive ready clear");
    wr(`DMIC_OFF_TX, 32'h1234_5678);
    @(negedge clk_sys);
    chk({tx_ready, dbg_tx_data}, {1'b1, 32'h1234_5678}, "transmit");
    rd(`DMIC_OFF_STAT, 32'h1);
    host.tx_drain();
    wr(`DMIC_OFF_STAT, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0);
    rd(`DMIC_OFF_STAT, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk(fq.size() + rq.size() + eq.size(), 0, "missing results");
    report_and_stop();
  end
endmodule : test_debug_mini_icache
